// File: core/mlsp_defines.vh
// constants shared by the multi-lane serial configuration port
`ifndef MLSP_DEFINES_VH
`define MLSP_DEFINES_VH

// ********************************************************************
// channel select register layout
// ********************************************************************
`define MLSP_CSR_ADDR 5'h00
`define MLSP_CSR_RESET 8'hf0
`define MLSP_CSR_LSB_BIT 0
`define MLSP_CSR_MODE_LO 1
`define MLSP_CSR_MODE_HI 2
`define MLSP_CSR_CHEN_LO 4
`define MLSP_CSR_CHEN_HI 7

// ********************************************************************
// lane modes
// ********************************************************************
`define MLSP_MODE_2WIRE 2'b00
`define MLSP_MODE_3WIRE 2'b01
`define MLSP_MODE_2BIT 2'b10
`define MLSP_MODE_4BIT 2'b11

// ********************************************************************
// instruction byte fields
// ********************************************************************
`define MLSP_DIR_BIT 7
`define MLSP_ADDR_HI 4
`define MLSP_ADDR_LO 0

// ********************************************************************
// register addresses and widths in bytes
// ********************************************************************
`define MLSP_ADDR_FR1 5'h01
`define MLSP_ADDR_FR2 5'h02
`define MLSP_ADDR_CFR 5'h03
`define MLSP_BYTES_1 3'd1
`define MLSP_BYTES_2 3'd2
`define MLSP_BYTES_3 3'd3
`define MLSP_BYTES_4 3'd4

// ********************************************************************
// misc widths and counts
// ********************************************************************
`define MLSP_BITS_PER_BYTE 4'd8
`define MLSP_LANE_1 3'd1
`define MLSP_LANE_2 3'd2
`define MLSP_LANE_4 3'd4
`define MLSP_MEM_WORDS 128
`define MLSP_SYNC_DIV_LAST 2'd3
`define MLSP_SYNC_DIV_RISE 2'd1

`endif

// File: core/mlsp_port.v
// serial configuration port controller with one, two or four data lanes
`timescale 1ns/1ps
`default_nettype none
`include "mlsp_defines.vh"

module mlsp_port (
  input wire clk,
  input wire rstn,
  input wire sclk,
  input wire chip_select_low_n,
  input wire [3:0] sdio_in,
  output reg [3:0] sdio_out,
  output reg [3:0] sdio_oe,
  input wire io_update,
  output wire sync_clk,
  output reg update_commit,
  output wire [3:0] channel_enable,
  output reg [1:0] amplitude_ramp_control,
  output reg cycle_active,
  output reg cycle_aborted,
  input wire [6:0] core_addr,
  output wire [7:0] core_data
);

  // ********************************************************************
  // states and helpers
  // ********************************************************************
  localparam [2:0] ST_INSTR = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_ABORT = 3'b100;

  function [2:0] lane_width;
    input [1:0] mode;
    begin
      case (mode)
        `MLSP_MODE_4BIT: lane_width = `MLSP_LANE_4;
        `MLSP_MODE_2BIT: lane_width = `MLSP_LANE_2;
        default: lane_width = `MLSP_LANE_1;
      endcase
    end
  endfunction

  // register width by address; unlisted addresses hold four bytes
  function [2:0] reg_bytes;
    input [4:0] addr;
    begin
      case (addr)
        `MLSP_CSR_ADDR: reg_bytes = `MLSP_BYTES_1;
        `MLSP_ADDR_FR1: reg_bytes = `MLSP_BYTES_3;
        `MLSP_ADDR_FR2: reg_bytes = `MLSP_BYTES_2;
        `MLSP_ADDR_CFR: reg_bytes = `MLSP_BYTES_3;
        default: reg_bytes = `MLSP_BYTES_4;
      endcase
    end
  endfunction

  // shift one lane group into a byte in the selected order
  function [7:0] shift_in;
    input [7:0] cur;
    input [3:0] pins;
    input [2:0] w;
    input lsb;
    begin
      case (w)
        `MLSP_LANE_1: shift_in = lsb ? {pins[0], cur[7:1]} : {cur[6:0], pins[0]};
        `MLSP_LANE_2: shift_in = lsb ? {pins[1:0], cur[7:2]} : {cur[5:0], pins[1:0]};
        default: shift_in = lsb ? {pins, cur[7:4]} : {cur[3:0], pins};
      endcase
    end
  endfunction

  // ********************************************************************
  // channel select register: buffer and active copy
  // ********************************************************************
  reg [7:0] csr_buf;
  reg [2:0] csr_act;
  wire lsb_first = csr_act[`MLSP_CSR_LSB_BIT];
  wire [1:0] mode = csr_act[`MLSP_CSR_MODE_HI:`MLSP_CSR_MODE_LO];
  wire [2:0] width = lane_width(mode);

  assign channel_enable = csr_buf[`MLSP_CSR_CHEN_HI:`MLSP_CSR_CHEN_LO];

  // ********************************************************************
  // update strobe sampled on the divided clock
  // ********************************************************************
  reg [1:0] sync_div;
  reg upd_sampled;
  // leaving count 1 is the edge on which sync_clk goes high
  wire sync_rise = (sync_div == `MLSP_SYNC_DIV_RISE);
  assign sync_clk = sync_div[1];

  always @(posedge clk) begin
    if (!rstn) begin
      sync_div <= 2'd0;
      upd_sampled <= 1'b0;
      update_commit <= 1'b0;
    end else begin
      sync_div <= sync_div + 2'd1;
      update_commit <= 1'b0;
      if (sync_rise) begin
        // one commit per strobe however long it is held
        upd_sampled <= io_update;
        update_commit <= io_update & ~upd_sampled;
      end
    end
  end

  // ********************************************************************
  // serial clock edges; ignored while chip select is high
  // ********************************************************************
  reg sclk_q;
  wire selected = ~chip_select_low_n;
  wire sclk_rise = selected & sclk & ~sclk_q;
  wire sclk_fall = selected & ~sclk & sclk_q;
  wire abort_pin = (mode != `MLSP_MODE_4BIT) & sdio_in[3];

  // ********************************************************************
  // cycle state
  // ********************************************************************
  reg [2:0] state;
  reg [7:0] in_shift;
  reg [3:0] bit_cnt;
  reg is_read;
  reg [4:0] reg_addr;
  reg [1:0] byte_idx;
  reg [2:0] bytes_left;
  reg [7:0] out_shift;
  reg mem_wr;
  reg [7:0] mem_wdata;
  reg [6:0] mem_waddr;
  wire [7:0] mem_rdata;

  wire [7:0] next_byte = shift_in(in_shift, sdio_in, width, lsb_first);
  wire [3:0] next_cnt = bit_cnt + {1'b0, width};
  wire byte_done = (next_cnt == `MLSP_BITS_PER_BYTE);
  wire [4:0] instr_addr = next_byte[`MLSP_ADDR_HI:`MLSP_ADDR_LO];
  wire [2:0] instr_bytes = reg_bytes(instr_addr);
  wire [1:0] first_idx = lsb_first ? 2'd0 : instr_bytes[1:0] - 2'd1;
  wire [1:0] step_idx = lsb_first ? byte_idx + 2'd1 : byte_idx - 2'd1;
  wire [1:0] rd_idx = (state == ST_INSTR) ? first_idx : step_idx;
  wire [4:0] rd_reg = (state == ST_INSTR) ? instr_addr : reg_addr;
  reg [6:0] mem_raddr;
  wire [7:0] read_src = (reg_addr == `MLSP_CSR_ADDR) ? csr_buf : mem_rdata;

  always @(posedge clk) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      state <= ST_INSTR;
      in_shift <= 8'h00;
      bit_cnt <= 4'd0;
      is_read <= 1'b0;
      reg_addr <= 5'h00;
      byte_idx <= 2'd0;
      bytes_left <= 3'd0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      mem_waddr <= 7'h00;
      mem_raddr <= 7'h00;
      csr_buf <= `MLSP_CSR_RESET;
      csr_act <= 3'b000;
      cycle_aborted <= 1'b0;
    end else begin
      sclk_q <= sclk;
      mem_wr <= 1'b0;
      cycle_aborted <= 1'b0;
      if (update_commit) begin
        csr_act <= csr_buf[`MLSP_CSR_MODE_HI:`MLSP_CSR_LSB_BIT];
      end
      case (state)
        ST_INSTR: begin
          if (abort_pin) begin
            state <= ST_ABORT;
            bit_cnt <= 4'd0;
            cycle_aborted <= 1'b1;
          end else if (sclk_rise) begin
            in_shift <= next_byte;
            bit_cnt <= byte_done ? 4'd0 : next_cnt;
            if (byte_done) begin
              is_read <= next_byte[`MLSP_DIR_BIT];
              reg_addr <= instr_addr;
              byte_idx <= first_idx;
              bytes_left <= instr_bytes;
              mem_raddr <= {rd_reg, rd_idx};
              state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (abort_pin) begin
            // the partial byte is simply never written
            state <= ST_ABORT;
            bit_cnt <= 4'd0;
            cycle_aborted <= 1'b1;
          end else if (sclk_rise) begin
            in_shift <= next_byte;
            bit_cnt <= byte_done ? 4'd0 : next_cnt;
            if (byte_done) begin
              if (!is_read) begin
                if (reg_addr == `MLSP_CSR_ADDR) begin
                  csr_buf <= next_byte;
                end
                // the store keeps a copy of the channel select byte for the core
                mem_wr <= 1'b1;
                mem_wdata <= next_byte;
                mem_waddr <= {reg_addr, byte_idx};
              end
              byte_idx <= step_idx;
              mem_raddr <= {rd_reg, rd_idx};
              bytes_left <= bytes_left - 3'd1;
              if (bytes_left == 3'd1) begin
                state <= ST_INSTR;
              end
            end
          end
        end
        ST_ABORT: begin
          if (!abort_pin) begin
            state <= ST_INSTR;
          end
        end
        default: state <= ST_INSTR;
      endcase
    end
  end

  // ********************************************************************
  // read data driven on falling edges in the write order and lanes, except 3-wire mode, which reads out on pin 2
  // ********************************************************************
  wire reading = (state == ST_DATA) & is_read & selected;
  wire [7:0] src = (bit_cnt == 4'd0) ? read_src : out_shift;
  reg [3:0] chunk;
  reg [7:0] next_out_shift;
  reg [3:0] lane_mask;

  always @* begin
    chunk = 4'h0;
    next_out_shift = src;
    lane_mask = 4'h0;
    case (width)
      `MLSP_LANE_1: begin
        chunk[0] = lsb_first ? src[0] : src[7];
        next_out_shift = lsb_first ? {1'b0, src[7:1]} : {src[6:0], 1'b0};
        lane_mask = (mode == `MLSP_MODE_3WIRE) ? 4'b0100 : 4'b0001;
      end
      `MLSP_LANE_2: begin
        chunk[1:0] = lsb_first ? src[1:0] : src[7:6];
        next_out_shift = lsb_first ? {2'b00, src[7:2]} : {src[5:0], 2'b00};
        lane_mask = 4'b0011;
      end
      default: begin
        chunk = lsb_first ? src[3:0] : src[7:4];
        next_out_shift = lsb_first ? {4'h0, src[7:4]} : {src[3:0], 4'h0};
        lane_mask = 4'b1111;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      out_shift <= 8'h00;
      sdio_out <= 4'h0;
      sdio_oe <= 4'h0;
      amplitude_ramp_control <= 2'b00;
      cycle_active <= 1'b0;
    end else begin
      if (reading && sclk_fall) begin
        out_shift <= next_out_shift;
        // single lane in 3-wire mode goes to pin 2 only
        sdio_out <= (lane_mask == 4'b0100) ? {1'b0, chunk[0], 2'b00} : chunk;
      end
      // pins float while chip select is high
      sdio_oe <= reading ? lane_mask : 4'h0;
      amplitude_ramp_control[0] <= (width == `MLSP_LANE_1) & sdio_in[1];
      amplitude_ramp_control[1] <= (mode == `MLSP_MODE_2WIRE || mode == `MLSP_MODE_2BIT)
                                   & sdio_in[2];
      cycle_active <= (state == ST_DATA);
    end
  end

  // ********************************************************************
  // byte store
  // ********************************************************************
  mlsp_reg_mem u_mem (
    .clk(clk),
    .rstn(rstn),
    .wr_en(mem_wr),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata),
    .commit(update_commit),
    .core_addr(core_addr),
    .core_data(core_data)
  );

endmodule // mlsp_port
`default_nettype wire

// File: core/mlsp_reg_mem.v
// two-bank byte store: inactive buffer and active copy, registered reads
`timescale 1ns/1ps
`default_nettype none
`include "mlsp_defines.vh"

module mlsp_reg_mem (
  input wire clk,
  input wire rstn,
  input wire wr_en,
  input wire [6:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [6:0] rd_addr,
  output reg [7:0] rd_data,
  input wire commit,
  input wire [6:0] core_addr,
  output reg [7:0] core_data
);

  reg [7:0] buf_mem [0:`MLSP_MEM_WORDS-1];
  reg [7:0] act_mem [0:`MLSP_MEM_WORDS-1];

  // ********************************************************************
  // per-entry storage; commit copies every entry in one edge
  // ********************************************************************
  genvar i;
  generate
    for (i = 0; i < `MLSP_MEM_WORDS; i = i + 1) begin : g_entry
      always @(posedge clk) begin
        if (!rstn) begin
          // entry 0 mirrors the channel select byte, so it resets the same way
          buf_mem[i] <= (i == 0) ? `MLSP_CSR_RESET : 8'h00;
          act_mem[i] <= (i == 0) ? `MLSP_CSR_RESET : 8'h00;
        end else begin
          if (wr_en && wr_addr == i[6:0]) begin
            buf_mem[i] <= wr_data;
          end
          if (commit) begin
            act_mem[i] <= buf_mem[i];
          end
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
      core_data <= 8'h00;
    end else begin
      rd_data <= buf_mem[rd_addr];
      core_data <= act_mem[core_addr];
    end
  end

endmodule // mlsp_reg_mem
`default_nettype wire

// File: test/mlsp_host_model.sv
// behavioural host controller for the serial configuration pins
`timescale 1ns/1ps
`default_nettype none
module mlsp_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] d,
  input wire logic [3:0] q
);
  logic [1:0] mode = 2'b00;
  logic lsb = 1'b0;
  int w;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    d = 4'h0;
  end
  always_comb w = mode[1] ? (mode[0] ? 4 : 2) : 1;
  // ****
  // serial unit transfers
  // ****
  task automatic one(input logic [3:0] v, input logic drv, output logic [3:0] s);
    // a released line shows the inverse, never a stale copy of the last bit, except pin 3, held low outside 4-bit mode
    @(posedge clk) begin
      sclk <= 1'b0;
      d <= drv ? v : {mode == 2'b11 ? ~d[3] : 1'b0, ~d[2:0]};
    end
    repeat (4) @(posedge clk);
    s = (mode == 2'b01) ? {3'b000, q[2]} : q;
    sclk <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic close;
    repeat (3) @(posedge clk);
    sclk <= 1'b0;
    d <= 4'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic pause;
    @(posedge clk) cs_n <= 1'b1;
    repeat (3) @(posedge clk);
    sclk <= 1'b0;
    repeat (3) @(posedge clk);
    sclk <= 1'b1;
    repeat (3) @(posedge clk);
    cs_n <= 1'b0;
  endtask
  task automatic ramp(input logic [1:0] r);
    @(posedge clk) d <= {1'b0, r, 1'b0};
  endtask
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input int nb, input int ab,
                      output logic [31:0] rd);
    logic [7:0] b;
    logic [3:0] v, s;
    int n, i, k, c, j, bi, base;
    n = 8 / w;
    i = 0;
    rd = 32'h0;
    @(posedge clk) cs_n <= 1'b0;
    for (k = -1; k < nb; k++) begin
      bi = lsb ? k : nb - 1 - k;
      b = (k < 0) ? ins : wd[8 * bi +: 8];
      for (c = 0; c < n; c++) begin
        if (i == ab) begin
          @(posedge clk) d <= 4'h8;
          repeat (6) @(posedge clk);
          close;
          return;
        end
        if (i == 3) pause;
        base = lsb ? c * w : 8 - w - c * w;
        v = 4'h0;
        for (j = 0; j < w; j++) v[j] = b[base + j];
        one(v, k < 0 || !ins[7], s);
        for (j = 0; j < w; j++) if (k >= 0) rd[8 * bi + base + j] = s[j];
        i++;
      end
    end
    close;
  endtask
endmodule // mlsp_host_model
`default_nettype wire

// File: test/mlsp_port_properties.sv
// assertion checker bound to the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module mlsp_port_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic chip_select_low_n,
  input wire logic [3:0] sdio_in,
  input wire logic [3:0] sdio_out,
  input wire logic [3:0] sdio_oe,
  input wire logic io_update,
  input wire logic sync_clk,
  input wire logic update_commit,
  input wire logic [3:0] channel_enable,
  input wire logic [1:0] amplitude_ramp_control,
  input wire logic cycle_active,
  input wire logic cycle_aborted
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_commit_pulse; update_commit |=> !update_commit; endproperty
  a_commit_pulse: assert property (p_commit_pulse) else $error("commit too long");
  property p_commit_sync; update_commit |-> $rose(sync_clk); endproperty
  a_commit_sync: assert property (p_commit_sync) else $error("update not taken on sync rise");
  property p_commit_cause;
    update_commit |-> $past(io_update) || $past(io_update, 2) || $past(io_update, 3);
  endproperty
  a_commit_cause: assert property (p_commit_cause) else $error("commit without strobe");
  property p_sync_div; $rose(sync_clk) |=> !$rose(sync_clk) [*3] ##1 $rose(sync_clk); endproperty
  a_sync_div: assert property (p_sync_div) else $error("sync clock not clk/4");
  property p_oe_cs; chip_select_low_n && $past(chip_select_low_n) |-> sdio_oe == 4'h0; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("driving while deselected");
  property p_oe_pins; sdio_oe inside {4'h0, 4'h1, 4'h3, 4'h4, 4'hf}; endproperty
  a_oe_pins: assert property (p_oe_pins) else $error("bad output pin set");
  // low phase is long enough that every new read bit lands before the rise
  property p_out_fall;
    $changed(sdio_out) && sdio_oe != 4'h0 && $past(sdio_oe) != 4'h0 |-> !$past(sclk);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("read data moved on high clock");
  property p_abort_cause;
    $rose(cycle_aborted) |-> $past(sdio_in[3]) || $past(sdio_in[3], 2) || $past(sdio_in[3], 3);
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort without pin");
  property p_abort_end; cycle_aborted |-> ##[0:1] !cycle_active; endproperty
  a_abort_end: assert property (p_abort_end) else $error("cycle kept after abort");
  property p_ramp; (amplitude_ramp_control & ~$past(sdio_in[2:1])) == 2'b00; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp without pin");
  property p_chen; $changed(channel_enable) |-> !chip_select_low_n; endproperty
  a_chen: assert property (p_chen) else $error("enables moved without access");
  cover property (update_commit);
  cover property ($rose(cycle_aborted));
  cover property (sdio_oe == 4'hf);
endmodule // mlsp_port_chk
bind mlsp_port mlsp_port_chk mlsp_port_chk_i (
  .clk(clk), .rstn(rstn), .sclk(sclk), .chip_select_low_n(chip_select_low_n),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .io_update(io_update),
  .sync_clk(sync_clk), .update_commit(update_commit), .channel_enable(channel_enable),
  .amplitude_ramp_control(amplitude_ramp_control), .cycle_active(cycle_active),
  .cycle_aborted(cycle_aborted)
);
`default_nettype wire

// File: test/mlsp_port_tb.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module mlsp_port_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic io_update = 1'b0;
  logic [6:0] core_addr = 7'h00;
  wire sclk, cs_n, commit, sync_clk, active, aborted;
  wire [3:0] hd, sdio_in, sdio_out, sdio_oe, chen;
  wire [1:0] ramp;
  wire [7:0] core_data;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  integer seed = 32'h90b7;
  int aborts = 0;
  int commits = 0;
  int nupd = 0;
  int m, t, a, k, bi;
  logic [31:0] bufm [32];
  logic [31:0] act [32];
  logic [31:0] rd, wd;
  always #2.5 clk = ~clk;
  assign sdio_in = (sdio_oe & sdio_out) | (~sdio_oe & hd);
  mlsp_port mlsp_port_i (.clk(clk), .rstn(rstn), .sclk(sclk), .chip_select_low_n(cs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .io_update(io_update),
    .sync_clk(sync_clk), .update_commit(commit), .channel_enable(chen),
    .amplitude_ramp_control(ramp), .cycle_active(active), .cycle_aborted(aborted),
    .core_addr(core_addr), .core_data(core_data));
  mlsp_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .d(hd), .q(sdio_out));
  // ****
  // expectations and helpers
  // ****
  function automatic int nbytes(input logic [4:0] ra);
    return (ra == 5'h00) ? 1 : (ra == 5'h02) ? 2 : (ra < 5'h04) ? 3 : 4;
  endfunction
  function automatic logic [31:0] msk(input int n);
    return (n == 4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
  endfunction
  function automatic logic [1:0] exp_ramp(input logic [1:0] md, input logic [1:0] r);
    return {r[1] & ~md[0], r[0] & ~md[1]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic core_chk(input logic [4:0] ra);
    for (int j = 0; j < nbytes(ra); j++) begin
      @(posedge clk) core_addr <= {ra, j[1:0]};
      repeat (3) @(posedge clk);
      chk("core_data", {24'h0, core_data}, {24'h0, act[ra][8 * j +: 8]});
    end
  endtask
  task automatic update;
    @(posedge clk) io_update <= 1'b1;
    repeat (8) @(posedge clk);
    io_update <= 1'b0;
    repeat (8) @(posedge clk);
    nupd++;
    chk("commit_count", commits, nupd);
    for (int i = 0; i < 32; i++) act[i] = bufm[i];
  endtask
  // don't-care instruction bits are filled from the data to shake them
  task automatic wr_rd(input logic [4:0] ra, input logic [31:0] v);
    int nb;
    nb = nbytes(ra);
    host.xfer({1'b0, v[1:0], ra}, v & msk(nb), nb, -1, rd);
    bufm[ra] = v & msk(nb);
    host.xfer({1'b1, v[3:2], ra}, 32'h0, nb, -1, rd);
    chk("read_back", rd, bufm[ra]);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (aborted === 1'b1) aborts <= aborts + 1;
    if (commit === 1'b1) commits <= commits + 1;
    if (cycles == 100000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    for (int i = 0; i < 32; i++) bufm[i] = 32'h0;
    bufm[0] = 32'hf0;
    for (int i = 0; i < 32; i++) act[i] = bufm[i];
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("chen_reset", {28'h0, chen}, 32'hf);
    core_chk(5'h00);
    // every lane mode in both bit orders; 4-bit pair runs last
    for (m = 0; m < 8; m++) begin
      wd = $random(seed);
      wr_rd(5'h00, {wd[7:4], 1'b0, m[2:0]});
      chk("chen_now", {28'h0, chen}, {28'h0, wd[7:4]});
      core_chk(5'h00);
      update;
      host.mode = m[2:1];
      host.lsb = m[0];
      core_chk(5'h00);
      host.ramp(wd[9:8]);
      repeat (3) @(posedge clk);
      chk("ramp", {30'h0, ramp}, {30'h0, exp_ramp(m[2:1], wd[9:8])});
      host.ramp(2'b00);
      for (t = 0; t < 4; t++) begin
        a = (t < 3) ? t + 1 : 4 + ($random(seed) & 27);
        wr_rd(a[4:0], (t == 2) ? 32'hffffffff : $random(seed));
      end
      core_chk(5'h01);
      update;
      core_chk(5'h01);
      if (m < 6) begin
        wd = $random(seed);
        k = 8 / host.w;
        host.xfer(8'h61, wd, 3, 2 * k + k / 2, rd);
        chk("abort_count", aborts, m + 1);
        chk("active_after_abort", {31'h0, active}, 32'h0);
        bi = m[0] ? 0 : 2;
        bufm[1][8 * bi +: 8] = wd[8 * bi +: 8];
        host.xfer(8'he1, 32'h0, 3, -1, rd);
        chk("abort_keep", rd, bufm[1]);
      end
    end
    print_verdict;
  end
endmodule // mlsp_port_tb
`default_nettype wire
